// >>> light_source_start_sequencer.v
// Purpose: start, stop and fault sequencing for a laser-pumped plasma lamp
// Assumes: 40 MHz clk, asynchronous active-low power-on reset, AXI4-Lite access
// Notes: status pins are open-drain; a _pull_n output low pulls the pin to common
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "light_regs.vh"

module light_source_start_sequencer #(
  parameter [`TMR_W-1:0] IGN_TIMEOUT_CYC = `IGN_TIMEOUT_S * `CLK_HZ,
  parameter [`TMR_W-1:0] WARMUP_CYC = `WARMUP_MIN_S * `CLK_HZ,
  parameter [`TMR_W-1:0] SETTLE_CYC = `LASER_SETTLE_MS * `CLK_KHZ,
  parameter [`TMR_W-1:0] IGNITE_CYC = `IGNITE_PULSE_MS * `CLK_KHZ,
  parameter [`DEB_W-1:0] DEB_CYC = `DEB_CYC_DEF
) (
  input wire clk,
  input wire rst_n,
  input wire operate_req,
  input wire interlock_ok,
  input wire ignition_ready,
  input wire plasma_sense,
  output reg laser_en_q,
  output reg igniter_q,
  output reg lamp_on_pull_n_q,
  output reg laser_on_pull_n_q,
  output reg head_fault_pull_n_q,
  output reg supply_fault_pull_n_q,
  output reg irq_q,
  input wire [31:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output wire [1:0] s_bresp,
  output wire s_bvalid,
  input wire s_bready,
  input wire [31:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0] s_rresp,
  output wire s_rvalid,
  input wire s_rready
);

  // one-hot sequencer states
  localparam [4:0] ST_IDLE = 5'b00001; // laser off, waiting for request
  localparam [4:0] ST_SETTLE = 5'b00010; // laser on, pump coming up
  localparam [4:0] ST_WARMUP = 5'b00100; // pump active, waiting for ignition conditions
  localparam [4:0] ST_IGNITE = 5'b01000; // igniter firing
  localparam [4:0] ST_LIT = 5'b10000; // plasma burning

  // number of conditioned inputs
  localparam integer N_IN = 4;

  // address decode shared by read and write paths
  function [2:0] reg_sel;
    input [31:0] addr;
    begin
      if (addr == `OFS_CTRL) begin
        reg_sel = `SEL_CTRL;
      end else if (addr == `OFS_STATUS) begin
        reg_sel = `SEL_STATUS;
      end else if (addr == `OFS_IRQ_STAT) begin
        reg_sel = `SEL_IRQ_STAT;
      end else if (addr == `OFS_IRQ_MASK) begin
        reg_sel = `SEL_IRQ_MASK;
      end else begin
        reg_sel = `SEL_NONE;
      end
    end
  endfunction

  wire [N_IN-1:0] raw_in; // pins as they arrive
  wire [N_IN-1:0] clean_in; // synchronised, debounced levels
  wire op_db; // debounced operate request
  wire ilk_db; // debounced interlock, high when closed
  wire ready_db; // ignition conditions reached
  wire plasma_db; // plasma detected

  reg [4:0] state_q; // sequencer state
  reg [4:0] state_d;
  reg [`TMR_W-1:0] run_cnt_q; // cycles since the start was accepted
  reg [`TMR_W-1:0] phase_cnt_q; // cycles spent in current state
  reg op_prev_q; // operate level one cycle ago
  reg head_flt_q; // latched head-unit fault
  reg supply_flt_q; // latched supply-unit fault
  reg set_head; // head fault raised this cycle
  reg set_supply; // supply fault raised this cycle
  reg ctrl_en_q; // software start enable
  reg [`IRQ_W-1:0] irq_stat_q; // sticky events
  reg [`IRQ_W-1:0] irq_mask_q; // event enables
  reg [`IRQ_W-1:0] irq_ev; // events this cycle
  reg [31:0] rd_data; // read mux
  wire op_fall; // operate request released
  wire any_flt; // some fault latched
  wire active; // sequencer not idle
  wire wr_en; // register write strobe
  wire [31:0] wr_addr_q;
  wire [31:0] wr_data_q;
  wire [3:0] wr_strb_q;
  wire [2:0] wr_sel; // decoded write target
  wire [2:0] rd_sel; // decoded read target

  assign raw_in = {plasma_sense, ignition_ready, interlock_ok, operate_req};
  assign op_db = clean_in[0];
  assign ilk_db = clean_in[1];
  assign ready_db = clean_in[2];
  assign plasma_db = clean_in[3];

  // condition every pin before the sequencer looks at it
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_cond
      input_conditioner #(
        .DEB_CYC(DEB_CYC)
      ) u_cond (
        .clk(clk),
        .rst_n(rst_n),
        .raw(raw_in[gi]),
        .clean_q(clean_in[gi])
      );
    end
  endgenerate

  assign op_fall = op_prev_q & ~op_db;
  assign any_flt = head_flt_q | supply_flt_q;
  assign active = ~state_q[0];

  // next state and fault raising
  always @* begin
    state_d = state_q;
    set_head = 1'b0;
    set_supply = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // start needs request, closed interlock, no fault, enable
        if (op_db & ilk_db & ~any_flt & ctrl_en_q) begin
          state_d = ST_SETTLE;
        end
      end
      ST_LIT: begin
        if (~ilk_db) begin
          state_d = ST_IDLE;
          set_supply = 1'b1;
        end else if (~op_db) begin
          state_d = ST_IDLE;
        end else if (~plasma_db) begin
          // plasma lost while burning
          state_d = ST_IDLE;
          set_head = 1'b1;
        end
      end
      default: begin
        // settle, warm-up and ignite share the abort paths
        if (~ilk_db) begin
          state_d = ST_IDLE;
          set_supply = 1'b1;
        end else if (~op_db) begin
          state_d = ST_IDLE;
        end else if (state_q == ST_IGNITE && plasma_db) begin
          state_d = ST_LIT;
        end else if (run_cnt_q >= IGN_TIMEOUT_CYC - 33'd1) begin
          state_d = ST_IDLE;
          set_head = 1'b1;
        end else if (state_q == ST_SETTLE) begin
          if (phase_cnt_q >= SETTLE_CYC - 33'd1) begin
            state_d = ST_WARMUP;
          end
        end else if (state_q == ST_WARMUP) begin
          // minimum warm-up passed and conditions right
          if (run_cnt_q >= WARMUP_CYC - 33'd1 && ready_db) begin
            state_d = ST_IGNITE;
          end
        end else if (phase_cnt_q >= IGNITE_CYC - 33'd1) begin
          // no plasma after one shot: back to warm-up and retry
          state_d = ST_WARMUP;
        end
      end
    endcase
  end

  // state and timers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      run_cnt_q <= {`TMR_W{1'b0}};
      phase_cnt_q <= {`TMR_W{1'b0}};
      op_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_prev_q <= op_db;
      // timeout measured from the accepted request
      if (state_d == ST_IDLE || state_q == ST_IDLE) begin
        run_cnt_q <= {`TMR_W{1'b0}};
      end else if (run_cnt_q != IGN_TIMEOUT_CYC) begin
        run_cnt_q <= run_cnt_q + 33'd1;
      end
      if (state_d != state_q) begin
        phase_cnt_q <= {`TMR_W{1'b0}};
      end else begin
        phase_cnt_q <= phase_cnt_q + 33'd1;
      end
    end
  end

  // fault latches: raising wins over the clearing edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_flt_q <= 1'b0;
      supply_flt_q <= 1'b0;
    end else begin
      if (set_head) begin
        head_flt_q <= 1'b1;
      end else if (op_fall) begin
        head_flt_q <= 1'b0;
      end
      if (set_supply) begin
        supply_flt_q <= 1'b1;
      end else if (op_fall) begin
        supply_flt_q <= 1'b0;
      end
    end
  end

  // drive outputs from next state so pins follow without lag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laser_en_q <= 1'b0;
      igniter_q <= 1'b0;
      lamp_on_pull_n_q <= 1'b1;
      laser_on_pull_n_q <= 1'b1;
      head_fault_pull_n_q <= 1'b0;
      supply_fault_pull_n_q <= 1'b0;
    end else begin
      laser_en_q <= ~state_d[0];
      igniter_q <= state_d[3];
      // pulled low while true, released otherwise
      lamp_on_pull_n_q <= ~state_d[4];
      laser_on_pull_n_q <= ~(state_d[2] | state_d[3] | state_d[4]);
      // pulled low while healthy, floated on fault
      head_fault_pull_n_q <= head_flt_q | set_head;
      supply_fault_pull_n_q <= supply_flt_q | set_supply;
    end
  end

  // event sources for the interrupt status
  always @* begin
    irq_ev = {`IRQ_W{1'b0}};
    irq_ev[`EV_PUMP] = state_d[2] & state_q[1];
    irq_ev[`EV_LIT] = state_d[4] & ~state_q[4];
    irq_ev[`EV_HFLT] = set_head;
    irq_ev[`EV_SFLT] = set_supply;
  end

  // bus handshake
  axi_lite_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr_q(wr_addr_q),
    .wr_data_q(wr_data_q),
    .wr_strb_q(wr_strb_q),
    .wr_err(wr_sel == `SEL_NONE),
    .rd_data(rd_data),
    .rd_err(rd_sel == `SEL_NONE)
  );

  assign wr_sel = reg_sel(wr_addr_q);
  assign rd_sel = reg_sel(s_araddr);

  // software registers; all writable fields sit in byte lane 0
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_q <= `CTRL_RST;
      irq_mask_q <= `IRQ_MASK_RST;
      irq_stat_q <= {`IRQ_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      if (wr_en && wr_strb_q[0] && wr_sel == `SEL_CTRL) begin
        ctrl_en_q <= wr_data_q[`CTRL_EN_BIT];
      end
      if (wr_en && wr_strb_q[0] && wr_sel == `SEL_IRQ_MASK) begin
        irq_mask_q <= wr_data_q[`IRQ_W-1:0];
      end
      // write one to clear; a new event in the same cycle stays set
      if (wr_en && wr_strb_q[0] && wr_sel == `SEL_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wr_data_q[`IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read mux, zero for unmapped addresses and unused bits
  always @* begin
    rd_data = 32'h0000_0000;
    if (rd_sel == `SEL_CTRL) begin
      rd_data[`CTRL_EN_BIT] = ctrl_en_q;
    end else if (rd_sel == `SEL_STATUS) begin
      rd_data[`ST_LASER_BIT] = active;
      rd_data[`ST_PUMP_BIT] = state_q[2] | state_q[3] | state_q[4];
      rd_data[`ST_IGN_BIT] = state_q[3];
      rd_data[`ST_LIT_BIT] = state_q[4];
      rd_data[`ST_HFLT_BIT] = head_flt_q;
      rd_data[`ST_SFLT_BIT] = supply_flt_q;
      rd_data[`ST_OP_BIT] = op_db;
      rd_data[`ST_ILK_BIT] = ilk_db;
      rd_data[`ST_STATE_LSB +: 5] = state_q;
    end else if (rd_sel == `SEL_IRQ_STAT) begin
      rd_data[`IRQ_W-1:0] = irq_stat_q;
    end else if (rd_sel == `SEL_IRQ_MASK) begin
      rd_data[`IRQ_W-1:0] = irq_mask_q;
    end
  end

endmodule // light_source_start_sequencer

// >>> light_regs.vh
// Purpose: shared constants of the light source start sequencer
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite register window
// Notes: definitions only, no logic
`ifndef LIGHT_REGS_VH
`define LIGHT_REGS_VH

// clock rate and timing figures in their own units
`define CLK_HZ 33'd40000000
`define CLK_KHZ 33'd40000
`define DEBOUNCE_MS 33'd10
`define LASER_SETTLE_MS 33'd2000
`define WARMUP_MIN_S 33'd20
`define IGN_TIMEOUT_S 33'd150
`define IGNITE_PULSE_MS 33'd500

// counter widths
`define TMR_W 33
`define DEB_W 19

// default debounce span, 10 ms of clk
`define DEB_CYC_DEF 19'd400000

// register byte offsets
`define OFS_CTRL 32'h0000_0000
`define OFS_STATUS 32'h0000_0004
`define OFS_IRQ_STAT 32'h0000_0008
`define OFS_IRQ_MASK 32'h0000_000C

// register selector codes from the address decoder
`define SEL_NONE 3'h0
`define SEL_CTRL 3'h1
`define SEL_STATUS 3'h2
`define SEL_IRQ_STAT 3'h3
`define SEL_IRQ_MASK 3'h4

// control fields and reset values
`define CTRL_EN_BIT 0
`define CTRL_RST 1'b1
`define IRQ_W 4
`define IRQ_MASK_RST 4'h0

// status fields
`define ST_LASER_BIT 0
`define ST_PUMP_BIT 1
`define ST_IGN_BIT 2
`define ST_LIT_BIT 3
`define ST_HFLT_BIT 4
`define ST_SFLT_BIT 5
`define ST_OP_BIT 6
`define ST_ILK_BIT 7
`define ST_STATE_LSB 8

// interrupt event bits
`define EV_PUMP 0
`define EV_LIT 1
`define EV_HFLT 2
`define EV_SFLT 3

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> input_conditioner.v
// Purpose: two-stage synchroniser and debouncer for one level pin
// Assumes: raw input is asynchronous to clk
// Notes: output changes only after the synced level holds for DEB_CYC cycles
`timescale 1ns/1ps
`include "light_regs.vh"

module input_conditioner #(
  parameter [`DEB_W-1:0] DEB_CYC = `DEB_CYC_DEF
) (
  input wire clk,
  input wire rst_n,
  input wire raw,
  output reg clean_q
);

  reg meta_q; // first stage, read only by sync_q
  reg sync_q; // second stage
  reg [`DEB_W-1:0] cnt_q; // cycles the synced level has differed

  // synchroniser
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  // debounce: accept a new level once it stayed put long enough
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {`DEB_W{1'b0}};
      clean_q <= 1'b0;
    end else if (sync_q == clean_q) begin
      cnt_q <= {`DEB_W{1'b0}};
    end else if (cnt_q >= DEB_CYC - 19'd1) begin
      cnt_q <= {`DEB_W{1'b0}};
      clean_q <= sync_q;
    end else begin
      cnt_q <= cnt_q + 19'd1;
    end
  end

endmodule // input_conditioner

// >>> axi_lite_port.v
// Purpose: AXI4-Lite slave handshake for a small register file
// Assumes: one write and one read outstanding at most
// Notes: read data is sampled from rd_data at the address handshake
`timescale 1ns/1ps
`include "light_regs.vh"

module axi_lite_port (
  input wire clk,
  input wire rst_n,
  input wire [31:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [31:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  output wire wr_en,
  output reg [31:0] wr_addr_q,
  output reg [31:0] wr_data_q,
  output reg [3:0] wr_strb_q,
  input wire wr_err,
  input wire [31:0] rd_data,
  input wire rd_err
);

  reg aw_full_q; // write address held
  reg w_full_q; // write data held

  // commit once both halves are in and no response is pending
  assign wr_en = aw_full_q & w_full_q & ~s_bvalid;

  // write channels, taken in either order
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `RESP_OKAY;
      wr_addr_q <= 32'h0000_0000;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else begin
      if (s_awvalid & s_awready) begin
        aw_full_q <= 1'b1;
        wr_addr_q <= s_awaddr;
        s_awready <= 1'b0;
      end else if (~aw_full_q & ~s_bvalid) begin
        s_awready <= 1'b1;
      end
      if (s_wvalid & s_wready) begin
        w_full_q <= 1'b1;
        wr_data_q <= s_wdata;
        wr_strb_q <= s_wstrb;
        s_wready <= 1'b0;
      end else if (~w_full_q & ~s_bvalid) begin
        s_wready <= 1'b1;
      end
      if (wr_en) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `RESP_OKAY;
    end else if (s_arvalid & s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_data;
      s_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_rvalid & s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end else if (~s_rvalid) begin
      s_arready <= 1'b1;
    end
  end

endmodule // axi_lite_port

// >>> light_seq_props.sv
// Purpose: concurrent checks on the pins of the lamp start sequencer
// Assumes: bound to the top module, debounce shortened to 4 cycles in the bench
// Notes: status pins are open-drain, a _pull_n value of 0 means pulled to common
`timescale 1ns/1ps

module light_seq_props #(
  parameter [32:0] IGN_TIMEOUT_CYC = 33'd200
) (
  input wire clk,
  input wire rst_n,
  input wire operate_req,
  input wire interlock_ok,
  input wire laser_en_q,
  input wire igniter_q,
  input wire lamp_on_pull_n_q,
  input wire laser_on_pull_n_q,
  input wire head_fault_pull_n_q,
  input wire supply_fault_pull_n_q
);
  reg [32:0] dark_cnt_q; // cycles of laser on while the lamp is still dark
  wire [32:0] dark_cnt_d; // next dark count
  assign dark_cnt_d = (laser_en_q && lamp_on_pull_n_q) ? dark_cnt_q + 33'd1 : 33'd0;
  // count pump time without plasma
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dark_cnt_q <= 33'd0;
    end else begin
      dark_cnt_q <= dark_cnt_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_cause: assert property ($rose(laser_en_q) |-> $past(operate_req && interlock_ok))
    else $error("laser started without request and closed interlock");
  a_start_no_fault: assert property ($rose(laser_en_q) |-> $past(!head_fault_pull_n_q && !supply_fault_pull_n_q))
    else $error("laser started with a fault latched");
  a_laser_pin: assert property (!laser_on_pull_n_q |-> laser_en_q)
    else $error("laser status pulled while laser off");
  a_lit_pin: assert property (!lamp_on_pull_n_q |-> laser_en_q && !laser_on_pull_n_q)
    else $error("lamp status pulled without pump");
  a_igniter_gate: assert property (igniter_q |-> laser_en_q && lamp_on_pull_n_q)
    else $error("igniter fired without pump or after lit");
  a_stop_shuts: assert property (!operate_req [*8] |-> ##2 (!laser_en_q && lamp_on_pull_n_q))
    else $error("request dropped but lamp still running");
  a_ilk_trip: assert property (laser_en_q ##0 !interlock_ok [*8] |-> ##2 (!laser_en_q && supply_fault_pull_n_q))
    else $error("interlock open without shutdown and supply fault");
  a_dark_bound: assert property (dark_cnt_q <= IGN_TIMEOUT_CYC + 33'd2)
    else $error("pump left on past ignition timeout");
  a_lit_after_fire: assert property ($fell(lamp_on_pull_n_q) |-> $past(igniter_q))
    else $error("lamp lit without an igniter shot");
endmodule // light_seq_props

bind light_source_start_sequencer light_seq_props #(.IGN_TIMEOUT_CYC(IGN_TIMEOUT_CYC)) u_props (
  .clk(clk), .rst_n(rst_n), .operate_req(operate_req), .interlock_ok(interlock_ok),
  .laser_en_q(laser_en_q), .igniter_q(igniter_q), .lamp_on_pull_n_q(lamp_on_pull_n_q),
  .laser_on_pull_n_q(laser_on_pull_n_q), .head_fault_pull_n_q(head_fault_pull_n_q),
  .supply_fault_pull_n_q(supply_fault_pull_n_q));

// >>> lamp_head_model.sv
// Purpose: behavioural lamp head answering pump and igniter
// Assumes: ign_ok from the bench decides whether a strike succeeds
// Notes: plasma dies at once when the pump stops
`timescale 1ns/1ps

module lamp_head_model (
  input wire clk,
  input wire rst_n,
  input wire laser_en_q,
  input wire igniter_q,
  input wire ign_ok,
  output reg ignition_ready,
  output reg plasma_sense
);
  reg [5:0] warm_q; // pump-on time, saturates at 15
  // warm-up, ready flag and plasma state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= 6'h00;
      ignition_ready <= 1'b0;
      plasma_sense <= 1'b0;
    end else if (!laser_en_q) begin
      // no pump: cold and dark
      warm_q <= 6'h00;
      ignition_ready <= 1'b0;
      plasma_sense <= 1'b0;
    end else begin
      if (warm_q != 6'h0f) begin
        warm_q <= warm_q + 6'h01;
      end
      ignition_ready <= (warm_q == 6'h0f);
      if (igniter_q && ign_ok) begin
        plasma_sense <= 1'b1;
      end
    end
  end
endmodule // lamp_head_model

// >>> tb_light_source_start_sequencer.sv
// Purpose: self-checking bench for the lamp start sequencer
// Assumes: shortened timers, debounce 4 cycles, timeout 200 cycles
// Notes: pins are checked as {laser_en, lamp_n, head_n, supply_n}
`timescale 1ns/1ps
`include "light_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb_light_source_start_sequencer;
  logic clk = 0, rst_n = 0, operate_req = 0, interlock_ok = 0, ign_ok = 0;
  logic ignition_ready, plasma_sense, laser_en_q, igniter_q, irq_q;
  logic lamp_on_pull_n_q, laser_on_pull_n_q, head_fault_pull_n_q, supply_fault_pull_n_q;
  logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0, s_rdata, rd;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, rr;
  int fail_count = 0, checks = 0;
  // row: interlock, strike ok, expected pins while held
  typedef struct packed {logic ilk; logic ign; logic [3:0] pins;} row_t;
  row_t rows[3] = '{'{1'b1, 1'b1, 4'h8}, '{1'b1, 1'b0, 4'h6}, '{1'b0, 1'b1, 4'h4}};

  light_source_start_sequencer #(.IGN_TIMEOUT_CYC(33'd200), .WARMUP_CYC(33'd20),
    .SETTLE_CYC(33'd10), .IGNITE_CYC(33'd5), .DEB_CYC(19'd4)) u_dut (
    .clk(clk), .rst_n(rst_n), .operate_req(operate_req), .interlock_ok(interlock_ok),
    .ignition_ready(ignition_ready), .plasma_sense(plasma_sense), .laser_en_q(laser_en_q),
    .igniter_q(igniter_q), .lamp_on_pull_n_q(lamp_on_pull_n_q),
    .laser_on_pull_n_q(laser_on_pull_n_q), .head_fault_pull_n_q(head_fault_pull_n_q),
    .supply_fault_pull_n_q(supply_fault_pull_n_q), .irq_q(irq_q), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

  lamp_head_model u_head (.clk(clk), .rst_n(rst_n), .laser_en_q(laser_en_q),
    .igniter_q(igniter_q), .ign_ok(ign_ok), .ignition_ready(ignition_ready),
    .plasma_sense(plasma_sense));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one write, address and data offered together
  task automatic axi_wr(input [31:0] a, input [31:0] d, output [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
    forever begin
      @(posedge clk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 0;
      if (s_wvalid && s_wready) s_wvalid <= 0;
      if (s_bvalid && s_bready) begin
        r = s_bresp; s_bready <= 0; break;
      end
      if (n > 50) begin fail_count++; finish_test; end
    end
  endtask

  // one read
  task automatic axi_rd(input [31:0] a, output [31:0] d, output [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    forever begin
      @(posedge clk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 0;
      if (s_rvalid && s_rready) begin
        d = s_rdata; r = s_rresp; s_rready <= 0; break;
      end
      if (n > 50) begin fail_count++; finish_test; end
    end
  endtask

  function automatic [3:0] pins();
    return {laser_en_q, lamp_on_pull_n_q, head_fault_pull_n_q, supply_fault_pull_n_q};
  endfunction

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    `CHK("reset pins", 4'h4, pins())
    `CHK("laser pin", 1'b1, laser_on_pull_n_q)
    axi_rd(`OFS_CTRL, rd, rr);
    `CHK("ctrl reset", 32'h0000_0001, rd)
    axi_rd(`OFS_IRQ_MASK, rd, rr);
    `CHK("mask reset", 32'h0000_0000, rd)
    axi_wr(`OFS_IRQ_MASK, 32'h0000_000f, rr);
    `CHK("mask resp", `RESP_OKAY, rr)
    // ordinary start cycles: lit, timeout, interlock open
    foreach (rows[i]) begin
      @(posedge clk);
      interlock_ok <= rows[i].ilk; ign_ok <= rows[i].ign;
      repeat (20) @(posedge clk);
      operate_req <= 1;
      repeat (300) @(posedge clk);
      `CHK("run pins", rows[i].pins, pins())
      `CHK("pump pin", ~rows[i].pins[3], laser_on_pull_n_q)
      operate_req <= 0;
      repeat (20) @(posedge clk);
      `CHK("stop pins", 4'h4, pins())
    end
    `CHK("irq level", 1'b1, irq_q)
    axi_rd(`OFS_IRQ_STAT, rd, rr);
    `CHK("irq stat", 32'h0000_0007, rd)
    axi_wr(`OFS_IRQ_STAT, 32'h0000_000f, rr);
    repeat (3) @(posedge clk);
    `CHK("irq clear", 1'b0, irq_q)
    axi_rd(32'h0000_0010, rd, rr);
    `CHK("unmapped rd", `RESP_SLVERR, rr)
    `CHK("unmapped data", 32'h0000_0000, rd)
    axi_wr(32'h0000_0010, 32'h0000_0001, rr);
    `CHK("unmapped wr", `RESP_SLVERR, rr)
    // start disabled by software, only the supply event unmasked
    axi_wr(`OFS_CTRL, 32'h0000_0000, rr);
    axi_wr(`OFS_IRQ_MASK, 32'h0000_0008, rr);
    // interlock opens while lit, then closes with request still held
    interlock_ok <= 1; ign_ok <= 1; operate_req <= 1;
    repeat (50) @(posedge clk);
    `CHK("ctrl off pins", 4'h4, pins())
    axi_wr(`OFS_CTRL, 32'h0000_0001, rr);
    repeat (300) @(posedge clk);
    `CHK("lit pins", 4'h8, pins())
    `CHK("masked irq", 1'b0, irq_q)
    axi_rd(`OFS_STATUS, rd, rr);
    `CHK("status lit", 32'h0000_10cb, rd)
    `CHK("status resp", `RESP_OKAY, rr)
    interlock_ok <= 0;
    repeat (20) @(posedge clk);
    `CHK("trip pins", 4'h5, pins())
    `CHK("trip irq", 1'b1, irq_q)
    interlock_ok <= 1;
    repeat (50) @(posedge clk);
    `CHK("no restart", 4'h5, pins())
    operate_req <= 0;
    repeat (20) @(posedge clk);
    `CHK("fault cleared", 4'h4, pins())
    // reset during a start, then a fresh start with the request held
    operate_req <= 1;
    repeat (30) @(posedge clk);
    `CHK("mid start", 1'b1, laser_en_q)
    rst_n <= 0;
    repeat (2) @(posedge clk);
    `CHK("mid reset pins", 4'h4, pins())
    rst_n <= 1;
    repeat (2) @(posedge clk);
    `CHK("release pins", 4'h4, pins())
    repeat (300) @(posedge clk);
    `CHK("restart pins", 4'h8, pins())
    finish_test;
  end
endmodule // tb_light_source_start_sequencer
